// ==== rtl/rom_loader_pkg.sv ====
/*
 * Constants, types and timing for the serial identifier ROM loader.
 * Assumes a 100 MHz system clock and a three-wire serial ROM that
 * streams 16-bit words with an automatic address advance.
 */
package rom_loader_pkg;

    // System clock and serial ROM clock timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SCLK_PERIOD_NS   = 160;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // Strap settle time after reset release, in clock cycles
    localparam int SETTLE_CYCLES    = 4;

    // Word layout
    localparam int WORD_W           = 16;
    localparam int WORD_COUNT       = 3;
    localparam int GANG_BIT         = 14;
    localparam logic [15:0] WORD0_ZERO_MASK = 16'hBFFF;

    // Start bit, read opcode and word address, sent MSB first
    localparam int CMD_BITS         = 8;
    localparam logic [7:0] READ_CMD = 8'hC0;

    // Serial clock periods: command, then three data words
    localparam int PERIOD_W         = 6;
    localparam int TOTAL_PERIODS    = CMD_BITS + WORD_COUNT * WORD_W;
    localparam logic [3:0] WORD_END_NIBBLE = 4'h7;

    // Word indices
    localparam logic [1:0] IDX_GANG    = 2'h0;
    localparam logic [1:0] IDX_VENDOR  = 2'h1;
    localparam logic [1:0] IDX_PRODUCT = 2'h2;

    typedef enum {
        ST_SETTLE,
        ST_ACCESS,
        ST_DONE
    } load_state_t;

    typedef struct packed {
        logic [1:0]  index;
        logic [15:0] data;
    } rom_word_t;

endpackage : rom_loader_pkg

// ==== rtl/id_word_buffer.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module id_word_buffer #(
    parameter int W = 18
) (
    input  wire logic         ref_clk_i,
    input  wire logic         srst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);

    logic         head_valid_reg;
    logic [W-1:0] head_data_reg;
    logic         tail_valid_reg;
    logic [W-1:0] tail_data_reg;

    wire push = in_valid_i && !tail_valid_reg;
    wire pop  = head_valid_reg && out_ready_i;

    // Head is the output stage, so the output side sees plain flops
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            head_valid_reg <= 1'b0;
            tail_valid_reg <= 1'b0;
            head_data_reg  <= '0;
            tail_data_reg  <= '0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (!head_valid_reg) begin
                        head_valid_reg <= 1'b1;
                        head_data_reg  <= in_data_i;
                    end else begin
                        tail_valid_reg <= 1'b1;
                        tail_data_reg  <= in_data_i;
                    end
                end
                2'b01: begin
                    if (tail_valid_reg) begin
                        head_data_reg  <= tail_data_reg;
                        tail_valid_reg <= 1'b0;
                    end else begin
                        head_valid_reg <= 1'b0;
                    end
                end
                2'b11: begin
                    head_data_reg <= in_data_i;
                end
                default: begin
                end
            endcase
        end
    end

    assign in_ready_o  = !tail_valid_reg;
    assign out_valid_o = head_valid_reg;
    assign out_data_o  = head_data_reg;

endmodule : id_word_buffer

// ==== rtl/serial_rom_id_loader.sv ====
/*
 * One-shot loader of gang flag, vendor and product identifiers from a
 * three-wire serial ROM, with the received words also streamed out.
 * Assumes the ROM select follows power-on reset, the board resolves the
 * shared data wire from the enables, and pad pulldowns follow the
 * pulldown enable output.
 */
`timescale 1ns/100ps

module serial_rom_id_loader
    import rom_loader_pkg::*;
#(
    parameter int          SCLK_HALF          = SCLK_HALF_CYCLES,
    parameter logic [15:0] DEFAULT_VENDOR_ID  = 16'h0A5A,  // Arbitrary value
    parameter logic [15:0] DEFAULT_PRODUCT_ID = 16'h0B6B   // Arbitrary value
) (
    input  wire logic  ref_clk_i,
    input  wire logic  srst_i,
    input  wire logic  ext_rom_enable_n_i,
    input  wire logic  serial_rom_data_i,
    output logic       serial_rom_data_o,
    output logic       serial_rom_data_oe_o,
    output logic       serial_rom_clock_o,
    output logic       serial_rom_clock_oe_o,
    output logic       rom_pulldown_en_o,
    input  wire logic  word_ready_i,
    output logic       word_valid_o,
    output rom_word_t  word_o,
    output logic       gang_flag_o,
    output logic [15:0] vendor_identifier_o,
    output logic [15:0] product_identifier_o,
    output logic       ids_valid_o,
    output logic       format_error_o
);

    localparam int PH_W = $clog2(2 * SCLK_HALF);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * SCLK_HALF - 1);
    localparam logic [PH_W-1:0] PH_RISE = PH_W'(SCLK_HALF);

    function automatic logic [1:0] word_index(input logic [PERIOD_W-1:0] period);
        word_index = period[5:4] - 2'h1;
    endfunction : word_index

    function automatic logic cmd_bit(input logic [PERIOD_W-1:0] period);
        cmd_bit = READ_CMD[3'(CMD_BITS - 1) - period[2:0]];
    endfunction : cmd_bit

    logic                en_meta_reg;
    logic                en_sync_reg;
    logic                din_meta_reg;
    logic                din_sync_reg;
    load_state_t         state_reg;
    load_state_t         state_next;
    logic [2:0]          settle_reg;
    logic [PH_W-1:0]     phase_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic [15:0]         shift_reg;
    logic                sclk_reg;
    logic                sdata_reg;
    logic                sdata_oe_reg;
    logic                sclk_oe_reg;
    logic                pulldown_reg;
    logic                gang_reg;
    logic [15:0]         vendor_reg;
    logic [15:0]         product_reg;
    logic                ids_valid_reg;
    logic                fmt_err_reg;
    logic                buf_in_ready;
    logic [$bits(rom_word_t)-1:0] buf_out;

    // Two flops on both pins before any logic looks at them
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            en_meta_reg  <= 1'b1;
            en_sync_reg  <= 1'b1;
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            en_meta_reg  <= ext_rom_enable_n_i;
            en_sync_reg  <= en_meta_reg;
            din_meta_reg <= serial_rom_data_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    wire active     = (state_reg == ST_ACCESS);
    wire settled    = (settle_reg == 3'(SETTLE_CYCLES));
    // Stall only at a period boundary so the clock never stretches high
    wire advance    = active && ((phase_reg != '0) || buf_in_ready);
    wire phase_last = (phase_reg == PH_LAST);
    wire high_phase = (phase_reg >= PH_RISE);
    wire sending    = (period_reg < PERIOD_W'(CMD_BITS));
    wire last_cmd   = (period_reg == PERIOD_W'(CMD_BITS - 1));
    wire sample_en  = advance && phase_last;
    wire data_bit   = sample_en && !sending;
    wire word_done  = data_bit && (period_reg[3:0] == WORD_END_NIBBLE);
    wire [15:0] word_bits = {shift_reg[14:0], din_sync_reg};
    wire        word0_rsvd = |(word_bits & WORD0_ZERO_MASK);
    wire [1:0]  word_idx  = word_index(period_reg);
    wire access_end = sample_en && (period_reg == PERIOD_W'(TOTAL_PERIODS - 1));
    wire drive_data = active && sending && !(last_cmd && high_phase);

    rom_word_t push_word;
    assign push_word = '{index: word_idx, data: word_bits};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SETTLE: begin
                if (settled) begin
                    state_next = en_sync_reg ? ST_DONE : ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (access_end) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_DONE;
            end
            default: begin
                state_next = ST_DONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg  <= ST_SETTLE;
            settle_reg <= '0;
        end else begin
            state_reg  <= state_next;
            settle_reg <= settled ? settle_reg : settle_reg + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            phase_reg  <= '0;
            period_reg <= '0;
        end else if (advance) begin
            phase_reg  <= phase_last ? '0 : phase_reg + PH_W'(1);
            period_reg <= phase_last ? period_reg + PERIOD_W'(1) : period_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shift_reg <= '0;
        end else if (data_bit) begin
            shift_reg <= word_bits;
        end
    end

    // Pin outputs are registered: clock and data from the state, phase and period counters, pulldown from the synchronised enable
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sclk_reg     <= 1'b0;
            sclk_oe_reg  <= 1'b0;
            sdata_reg    <= 1'b0;
            sdata_oe_reg <= 1'b0;
            pulldown_reg <= 1'b0;
        end else begin
            sclk_reg     <= active && high_phase;
            sclk_oe_reg  <= active;
            sdata_reg    <= drive_data && cmd_bit(period_reg);
            sdata_oe_reg <= drive_data;
            pulldown_reg <= !en_sync_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gang_reg      <= 1'b0;
            vendor_reg    <= DEFAULT_VENDOR_ID;
            product_reg   <= DEFAULT_PRODUCT_ID;
            ids_valid_reg <= 1'b0;
            fmt_err_reg   <= 1'b0;
        end else begin
            if (word_done && word_idx == IDX_GANG) begin
                gang_reg    <= word_bits[GANG_BIT];
                fmt_err_reg <= word0_rsvd;
            end
            if (word_done && word_idx == IDX_VENDOR) begin
                vendor_reg <= word_bits;
            end
            if (word_done && word_idx == IDX_PRODUCT) begin
                product_reg <= word_bits;
            end
            if (state_next == ST_DONE) begin
                ids_valid_reg <= 1'b1;
            end
        end
    end

    id_word_buffer #(
        .W ($bits(rom_word_t))
    ) u_word_buffer (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (word_done),
        .in_data_i   (push_word),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (word_valid_o),
        .out_data_o  (buf_out),
        .out_ready_i (word_ready_i)
    );

    assign word_o                = buf_out;
    assign serial_rom_clock_o    = sclk_reg;
    assign serial_rom_clock_oe_o = sclk_oe_reg;
    assign serial_rom_data_o     = sdata_reg;
    assign serial_rom_data_oe_o  = sdata_oe_reg;
    assign rom_pulldown_en_o     = pulldown_reg;
    assign gang_flag_o           = gang_reg;
    assign vendor_identifier_o   = vendor_reg;
    assign product_identifier_o  = product_reg;
    assign ids_valid_o           = ids_valid_reg;
    assign format_error_o        = fmt_err_reg;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    property p_pulldown_on;
        !en_sync_reg |=> rom_pulldown_en_o;
    endproperty
    a_pulldown_on: assert property (p_pulldown_on) else $error("pulldown not enabled");

    property p_pulldown_off;
        en_sync_reg |=> !rom_pulldown_en_o;
    endproperty
    a_pulldown_off: assert property (p_pulldown_off) else $error("pulldown not disabled");

    property p_gang_latch;
        (word_done && word_idx == IDX_GANG) |=>
            (gang_flag_o == $past(word_bits[GANG_BIT])) &&
            (format_error_o == $past(word0_rsvd));
    endproperty
    a_gang_latch: assert property (p_gang_latch) else $error("gang word mislatched");

    property p_ids_latch;
        (word_done && word_idx == IDX_PRODUCT) |=>
            (product_identifier_o == $past(word_bits)) && word_valid_o;
    endproperty
    a_ids_latch: assert property (p_ids_latch) else $error("product id mislatched");

    property p_one_shot;
        $fell(serial_rom_clock_oe_o) |-> !serial_rom_clock_oe_o [*8];
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("read repeated");

    property p_command;
        (active && sending && phase_reg == PH_RISE) |->
            serial_rom_data_oe_o && (serial_rom_data_o == cmd_bit(period_reg));
    endproperty
    a_command: assert property (p_command) else $error("wrong command bit");

    property p_release;
        (active && !sending && phase_reg == PH_RISE) |-> !serial_rom_data_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("data line still driven");

    property p_clock_high;
        $rose(serial_rom_clock_o) |-> serial_rom_clock_oe_o && serial_rom_clock_o [*8] ##1 !serial_rom_clock_o;
    endproperty
    a_clock_high: assert property (p_clock_high) else $error("clock high phase wrong");

    property p_tristate;
        (state_reg == ST_DONE) |=> !serial_rom_clock_oe_o && !serial_rom_data_oe_o && ids_valid_o;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pins not released");

    property p_sample_point;
        sample_en |-> serial_rom_clock_o && !$past(sample_en);
    endproperty
    a_sample_point: assert property (p_sample_point) else $error("sample off high phase");

    property p_defaults;
        (state_reg == ST_SETTLE && settled && en_sync_reg) |=>
            ids_valid_o && vendor_identifier_o == DEFAULT_VENDOR_ID && !serial_rom_clock_oe_o;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not used");

    c_full_load: cover property (access_end);
    c_default:   cover property (state_reg == ST_SETTLE && settled && en_sync_reg);
    c_stall:     cover property (active && phase_reg == '0 && !buf_in_ready);
    c_fmt_err:   cover property ($rose(format_error_o));

endmodule : serial_rom_id_loader

// ==== verification/serial_rom_model.sv ====
/*
 * Behavioural three-wire serial ROM holding the three identifier words.
 * Assumes the select follows power-on reset and the bench resolves the
 * shared data wire from both enables.
 */
`timescale 1ns/100ps

module serial_rom_model (
    input  wire logic        sclk_i,
    input  wire logic        cs_i,
    input  wire logic        din_i,
    input  wire logic [47:0] words_i,
    input  wire logic [7:0]  tco_ns_i,
    output logic             dout_o,
    output logic             doe_o,
    output logic [7:0]       cmd_o
);
    int bit_cnt = 0;

    initial begin
        dout_o = 1'b0;
        doe_o  = 1'b0;
        cmd_o  = 8'h00;
    end

    always @(negedge cs_i) begin
        bit_cnt = 0;
        cmd_o   = 8'h00;
        doe_o  <= 1'b0;
    end

    // Output moves only after a rising clock, late by tco
    always @(posedge sclk_i) begin
        if (cs_i) begin
            if (bit_cnt < 8) cmd_o = {cmd_o[6:0], din_i};
            bit_cnt = bit_cnt + 1;
            if (bit_cnt == 8) begin
                doe_o  <= #(tco_ns_i) 1'b1;
                dout_o <= #(tco_ns_i) 1'b0;
            end else if (bit_cnt > 8 && bit_cnt <= 56) begin
                // Address advances by itself across the three words
                dout_o <= #(tco_ns_i) words_i[56 - bit_cnt];
            end
        end
    end
endmodule : serial_rom_model

// ==== verification/serial_rom_id_loader_bench.sv ====
/*
 * Self-checking bench for the serial identifier ROM loader.
 * Assumes the package, design files and ROM model are compiled first.
 */
`timescale 1ns/100ps

module serial_rom_id_loader_bench;
    import rom_loader_pkg::*;

    localparam logic [15:0] DEF_VID = 16'h1357;  // Arbitrary value
    localparam logic [15:0] DEF_PID = 16'h2468;  // Arbitrary value

    logic        ref_clk_i  = 1'b0;
    logic        srst_i     = 1'b1;
    logic        en_n       = 1'b0;
    logic        word_ready = 1'b1;
    logic        slow       = 1'b0;
    logic        float_bit  = 1'b0;
    logic [7:0]  tco        = 8'h01;
    logic [47:0] rom_words  = 48'h0;
    logic        data_wire, rom_d, rom_oe, dut_d, dut_doe, sclk, sclk_oe, pd_en;
    logic        wvalid, gang, ids_valid, fmt_err;
    logic [15:0] vendor_identifier, product_identifier;
    logic [7:0]  cmd;
    rom_word_t   word;
    rom_word_t   got_q[$];
    int          bad_count  = 0;
    int          n_tests    = 0;
    int          accesses   = 0;
    int          rises      = 0;
    int          cyc        = 0;

    always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

    // Undriven wire without pulldown must not look like a stable level
    assign data_wire = dut_doe ? dut_d : (rom_oe ? rom_d : (pd_en ? 1'b0 : float_bit));

    always @(posedge ref_clk_i) begin
        cyc       <= cyc + 1;
        float_bit <= ~float_bit;
        if (wvalid && word_ready) got_q.push_back(word);
    end

    // Slow consumer fills the buffer and forces clock stalls
    always @(posedge ref_clk_i) #1 word_ready = slow ? (cyc % 1024 >= 1000) : 1'b1;
    always @(posedge sclk_oe) accesses++;
    always @(posedge sclk) if (sclk_oe) rises++;

    serial_rom_id_loader #(
        .DEFAULT_VENDOR_ID  (DEF_VID),
        .DEFAULT_PRODUCT_ID (DEF_PID)
    ) i_dut (
        .ref_clk_i            (ref_clk_i),
        .srst_i               (srst_i),
        .ext_rom_enable_n_i   (en_n),
        .serial_rom_data_i    (data_wire),
        .serial_rom_data_o    (dut_d),
        .serial_rom_data_oe_o (dut_doe),
        .serial_rom_clock_o   (sclk),
        .serial_rom_clock_oe_o(sclk_oe),
        .rom_pulldown_en_o    (pd_en),
        .word_ready_i         (word_ready),
        .word_valid_o         (wvalid),
        .word_o               (word),
        .gang_flag_o          (gang),
        .vendor_identifier_o  (vendor_identifier),
        .product_identifier_o (product_identifier),
        .ids_valid_o          (ids_valid),
        .format_error_o       (fmt_err)
    );

    serial_rom_model i_rom (
        .sclk_i  (sclk_oe ? sclk : 1'b0),
        .cs_i    (~srst_i),
        .din_i   (data_wire),
        .words_i (rom_words),
        .tco_ns_i(tco),
        .dout_o  (rom_d),
        .doe_o   (rom_oe),
        .cmd_o   (cmd)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic do_reset(input logic enable_n);
        @(posedge ref_clk_i);
        #1 srst_i = 1'b1;
        en_n = enable_n;
        repeat (16) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        accesses = 0;
        rises    = 0;
        got_q.delete();
    endtask : do_reset

    task automatic wait_ids();
        int n;
        n = 0;
        while (ids_valid !== 1'b1 && n < 20000) begin
            @(posedge ref_clk_i);
            n++;
        end
        #1;
        check("ids valid", 1, ids_valid);
    endtask : wait_ids

    task automatic test_load(input logic [15:0] w0, w1, w2, input logic [7:0] t, input logic s,
                             input string name);
        logic [15:0] ew[3];
        int          n;
        ew = '{w0, w1, w2};
        tco = t;
        slow = s;
        rom_words = {w0, w1, w2};
        do_reset(1'b0);
        wait_ids();
        n = 0;
        while (got_q.size() < 3 && n < 3000) begin
            @(posedge ref_clk_i);
            n++;
        end
        #1;
        check("command", {1'b1, 2'b10, 5'b00000}, cmd);
        check("accesses", 1, accesses);
        check("clock rises", 8 + 3 * 16, rises);
        check("gang", w0[14], gang);
        check("format error", (w0 & WORD0_ZERO_MASK) != 16'h0000, fmt_err);
        check("vendor", w1, vendor_identifier);
        check("product", w2, product_identifier);
        check("clock oe", 0, sclk_oe);
        check("data oe", 0, dut_doe);
        check("pulldown on", 1, pd_en);
        check("word count", 3, got_q.size());
        foreach (got_q[i]) check("word", {2'(i), ew[i]}, got_q[i]);
        en_n = 1'b1;
        repeat (900) @(posedge ref_clk_i);
        #1;
        check("pulldown off", 0, pd_en);
        check("no repeat", 1, accesses);
        $display("Test %s done", name);
    endtask : test_load

    task automatic test_disabled();
        do_reset(1'b1);
        wait_ids();
        repeat (1200) @(posedge ref_clk_i);
        #1;
        check("default vendor", DEF_VID, vendor_identifier);
        check("default product", DEF_PID, product_identifier);
        check("gang", 0, gang);
        check("accesses", 0, accesses);
        check("pulldown", 0, pd_en);
        check("words", 0, got_q.size());
        $display("Test disabled done");
    endtask : test_disabled

    initial begin
        test_load(16'h4000, 16'hA1B2, 16'hC3D4, 8'h01, 1'b0, "prompt");
        test_load(16'h0000, 16'hFFFF, 16'h8001, 8'h28, 1'b1, "slow");
        test_load(16'h4008, 16'h0001, 16'h8000, 8'h14, 1'b0, "reserved");
        test_disabled();
        results();
    end

    // Four runs need about 8000 cycles; allow a wide margin
    initial begin
        #(40_000 * CLK_PERIOD_NS);
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        results();
    end
endmodule : serial_rom_id_loader_bench
